/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import wwd_pkg::*;
  // ----------------------------------------
  // signals, drivers and model
  // ----------------------------------------
  logic clk = 1'b0; // system clock
  logic rst_b = 1'b0; // reset, active low
  logic osc = 1'b0; // fast stand-in for the watchdog osc
  logic hsel = 1'b0; // bus select
  logic [1:0] htrans = 2'b00; // bus transfer kind
  logic [7:0] haddr = 8'h00; // bus address
  logic hwrite = 1'b0; // bus direction
  logic [31:0] hwdata = 32'h0; // bus write data
  logic [31:0] hrdata; // bus read data
  logic hreadyout; // slave ready
  logic hresp; // slave response
  logic chipResetReq; // reset request pulse
  logic wdtIrq; // interrupt level
  wwd_ahb_req_t ahbReq; // request bundle, hready looped back
  int mismatches = 0;
  int num_checks = 0;
  int rstPulses = 0; // reset requests seen
  int mdl[int]; // expected register values by offset
  logic [31:0] rd; // last read word
  int n; // cycles spent in last wait
  localparam logic [31:0] BEN = 32'h1 << MB_EN;
  localparam logic [31:0] BRST = 32'h1 << MB_RSTEN;
  localparam logic [31:0] BTO = 32'h1 << MB_TOFLAG;
  localparam logic [31:0] BWARN = 32'h1 << MB_WARN;
  localparam logic [31:0] BINT = 32'h1 << MB_INT;
  assign ahbReq = '{hsel, htrans, haddr, hwrite, 3'h2, hreadyout, hwdata};
  wwd_windowed_watchdog u_wwd_windowed_watchdog (
    .clk(clk), .rst_b(rst_b), .ahbReq(ahbReq), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dedicatedLowpowerOsc(osc), .chipResetReq(chipResetReq), .wdtIrq(wdtIrq));
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  // osc of 8 clk periods, odd phase so it never lines up with clk
  initial begin
    #3.3;
    forever #16 osc = ~osc;
  end
  // count reset requests to spot extra or missing pulses
  always @(posedge clk) begin
    if (chipResetReq === 1'b1) begin
      rstPulses <= rstPulses + 1;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task end_sim;
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hready wait, bounded so a dead slave cannot hang the run
  task waitRdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask
  // one single word transfer; model follows timeout writes only
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
    if (wr && a == OFS_TIMEOUT) begin
      mdl[a] = (wd[23:0] < TMIN) ? int'(TMIN) : int'(wd[23:0]);
    end
  endtask
  task rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  // wait for reset request or interrupt, sampled on the quiet edge
  task waitSig(input logic useIrq, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (((useIrq ? wdtIrq : chipResetReq) !== 1'b1) && n < lim);
    if (n >= lim) begin
      mismatches++;
      end_sim();
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h40ae));
    mdl[OFS_MODE] = 0;
    mdl[OFS_TIMEOUT] = int'(TRST);
    mdl[OFS_FEED] = 0;
    mdl[OFS_COUNT] = int'(TRST);
    mdl[OFS_WARN] = int'(WARNRST);
    mdl[OFS_WINDOW] = int'(WINRST);
    mdl[8'h18] = 0; // unmapped slot reads zero
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (mdl[a]) rdChk("reset value", 8'(a), 32'(mdl[a]));
    bus(1'b1, OFS_TIMEOUT, 32'h10);
    rdChk("timeout clamp", OFS_TIMEOUT, 32'(mdl[OFS_TIMEOUT]));
    bus(1'b1, OFS_TIMEOUT, $urandom & 32'hffffff | 32'h100);
    rdChk("timeout random", OFS_TIMEOUT, 32'(mdl[OFS_TIMEOUT]));
    bus(1'b1, OFS_TIMEOUT, 32'hff);
    bus(1'b1, OFS_MODE, BEN | BRST);
    bus(1'b1, OFS_MODE, 32'h0);
    rdChk("mode locked", OFS_MODE, BEN | BRST);
    // let the count run down a dozen ticks so the reload shows
    repeat (400) @(posedge clk);
    bus(1'b1, OFS_FEED, 32'(FEED1));
    bus(1'b1, OFS_FEED, 32'(FEED2));
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("reload", 32'(rd >= 32'hfe && rd <= 32'hff), 32'h1);
    waitSig(1'b0, 9000);
    chk("timeout delay", 32'(n > 8120 && n < 8220), 32'h1);
    @(negedge clk);
    chk("reset pulse", {31'h0, chipResetReq}, 32'h0);
    // warn compare still at zero, so the timeout tick also raised the warning
    rdChk("reset flag", OFS_MODE, BTO | BWARN);
    bus(1'b1, OFS_MODE, BTO | BWARN);
    bus(1'b1, OFS_WARN, 32'h80);
    bus(1'b1, OFS_MODE, BEN);
    waitSig(1'b1, 6000);
    chk("warn delay", 32'(n > 4000 && n < 4160), 32'h1);
    rdChk("warn flag", OFS_MODE, BEN | BWARN);
    bus(1'b1, OFS_MODE, BWARN);
    @(negedge clk);
    chk("warn cleared", {31'h0, wdtIrq}, 32'h0);
    waitSig(1'b1, 6000);
    rdChk("fault irq", OFS_MODE, BINT);
    chk("no reset in irq mode", 32'(rstPulses), 32'h1);
    bus(1'b1, OFS_MODE, BINT);
    // feed too early: count still above the window
    bus(1'b1, OFS_WINDOW, 32'h10);
    bus(1'b1, OFS_MODE, BEN);
    bus(1'b1, OFS_FEED, 32'(FEED1));
    bus(1'b1, OFS_FEED, 32'(FEED2));
    waitSig(1'b1, 20);
    rdChk("window fault", OFS_MODE, BINT);
    bus(1'b1, OFS_MODE, BINT);
    // feed inside the window: count has dropped below the bound
    bus(1'b1, OFS_WINDOW, 32'hf8);
    bus(1'b1, OFS_MODE, BEN);
    repeat (400) @(posedge clk);
    bus(1'b1, OFS_FEED, 32'(FEED1));
    bus(1'b1, OFS_FEED, 32'(FEED2));
    rdChk("in-window reload", OFS_MODE, BEN);
    bus(1'b1, OFS_WINDOW, 32'(WINRST));
    // second feed byte with no first byte before it
    bus(1'b1, OFS_MODE, BEN | BRST);
    bus(1'b1, OFS_FEED, 32'(FEED2));
    waitSig(1'b0, 20);
    rdChk("bad feed", OFS_MODE, BTO);
    bus(1'b1, OFS_MODE, BEN | BRST);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rdChk("hw reset", OFS_MODE, 32'h0);
    end_sim();
  end
endmodule // testbench

/* wwd_pkg.sv */
package wwd_pkg;
  // ----------------------------------------
  // register map, word aligned byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;    // enable, reset select, flags
  localparam logic [7:0] OFS_TIMEOUT = 8'h04; // reload value
  localparam logic [7:0] OFS_FEED = 8'h08;    // feed sequence port
  localparam logic [7:0] OFS_COUNT = 8'h0c;   // live count, read only
  localparam logic [7:0] OFS_WARN = 8'h10;    // warning compare value
  localparam logic [7:0] OFS_WINDOW = 8'h14;  // window upper bound
  // ----------------------------------------
  // mode register fields
  // ----------------------------------------
  localparam int MB_EN = 0;      // set only enable
  localparam int MB_RSTEN = 1;   // set only: fault resets chip
  localparam int MB_TOFLAG = 2;  // watchdog reset happened, w1c
  localparam int MB_WARN = 3;    // warning flag, w1c
  localparam int MB_INT = 4;     // fault interrupt flag, w1c
  // ----------------------------------------
  // counter and feed constants
  // ----------------------------------------
  localparam int CW = 24;                          // counter width
  localparam logic [CW-1:0] TMIN = 24'h0000ff;     // 256 ticks minimum
  localparam logic [CW-1:0] TRST = 24'h00ffff;     // timeout at reset
  localparam logic [CW-1:0] WINRST = 24'hffffff;   // window open
  localparam logic [CW-1:0] WARNRST = 24'h000000;  // warning compare
  localparam logic [7:0] FEED1 = 8'haa;            // first feed byte
  localparam logic [7:0] FEED2 = 8'h55;            // second feed byte
  localparam int PRESC_DIV = 4;                    // osc edges per tick
  localparam int OSC_KHZ = 503;                    // nominal osc rate
  localparam int CLK_KHZ = 250000;                 // system clock rate
  localparam int CLK_PER_OSC = CLK_KHZ / OSC_KHZ;  // sys cycles per osc cycle
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [7:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } wwd_ahb_req_t;

  typedef struct packed {
    logic [2:0] osc;       // osc synchroniser plus edge stage
    logic [1:0] pre;       // prescaler
    logic en;
    logic rstEn;
    logic toFlag;
    logic warnFlag;
    logic intFlag;
    logic feedArm;         // first feed byte seen
    logic chipRst;         // one cycle reset request
    logic [CW-1:0] tmo;
    logic [CW-1:0] warn;
    logic [CW-1:0] win;
    logic [CW-1:0] cnt;
    logic dWr;             // data phase write pending
    logic [7:0] dAddr;
    logic [31:0] rdata;
  } wwd_state_t;
endpackage

/* wwd_windowed_watchdog.sv */
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module wwd_windowed_watchdog (
  input wire logic clk,                       // 250 MHz system clock
  input wire logic rst_b,                     // async reset, active low
  input wire wwd_pkg::wwd_ahb_req_t ahbReq,   // ahb-lite request
  output logic [31:0] hrdata,                 // read data
  output logic hreadyout,                     // always ready
  output logic hresp,                         // always okay
  input wire logic dedicatedLowpowerOsc,      // watchdog osc, asynchronous
  output logic chipResetReq,                  // one cycle reset request
  output logic wdtIrq                         // warning or fault interrupt
);
  import wwd_pkg::*;

  // ----------------------------------------
  // state and events
  // ----------------------------------------
  wwd_state_t s_q, s_d;  // all state
  logic tick;            // one prescaled watchdog tick
  logic feedWr;          // write to feed port this cycle
  logic goodFeed;        // completed feed sequence
  logic badFeed;         // broken feed sequence
  logic outWin;          // reload too early in window mode
  logic timeoutEv;       // count ran out
  logic fault;           // any fault while enabled

  // read mux, shared by the address phase capture
  function automatic logic [31:0] rdVal(input logic [7:0] a, input wwd_state_t st);
    case (a)
      OFS_MODE: rdVal = {27'h0000000, st.intFlag, st.warnFlag, st.toFlag, st.rstEn, st.en};
      OFS_TIMEOUT: rdVal = {8'h00, st.tmo};
      OFS_COUNT: rdVal = {8'h00, st.cnt};
      OFS_WARN: rdVal = {8'h00, st.warn};
      OFS_WINDOW: rdVal = {8'h00, st.win};
      default: rdVal = 32'h00000000;  // feed and unmapped read zero
    endcase
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] wd;
    wd = ahbReq.hwdata;
    s_d = s_q;
    s_d.chipRst = 1'b0;
    // osc passes two flops before the edge stage reads it
    // a nominal 503 kHz osc spans ~500 clk, so no osc edge is lost
    s_d.osc = {s_q.osc[1:0], dedicatedLowpowerOsc};
    tick = 1'b0;
    // prescaler divides osc edges by four
    if (s_q.osc[1] && !s_q.osc[2]) begin
      s_d.pre = s_q.pre + 2'd1;
      tick = (s_q.pre == 2'(PRESC_DIV - 1));
    end
    feedWr = s_q.dWr && (s_q.dAddr == OFS_FEED);
    goodFeed = feedWr && s_q.feedArm && (wd[7:0] == FEED2);
    // anything but the second byte after the first, or a lone second byte
    badFeed = feedWr && (s_q.feedArm ? (wd[7:0] != FEED2) : (wd[7:0] == FEED2));
    outWin = goodFeed && (s_q.cnt > s_q.win);
    // no sleep gating: counter runs whenever enabled and the osc runs
    timeoutEv = tick && (s_q.cnt == '0);  // period is tmo+1 ticks
    fault = s_q.en && (timeoutEv || badFeed || outWin);
    // feed sequence tracking
    if (feedWr) begin
      s_d.feedArm = !s_q.feedArm && (wd[7:0] == FEED1);
    end
    // count down on every tick while enabled
    if (s_q.en && tick && !timeoutEv) begin
      s_d.cnt = s_q.cnt - 24'd1;
    end
    if (s_q.en && tick && (s_q.cnt == s_q.warn)) begin
      s_d.warnFlag = 1'b1;
    end
    // register writes, data phase
    if (s_q.dWr) begin
      case (s_q.dAddr)
        OFS_MODE: begin
          if (wd[MB_EN] && !s_q.en) begin
            s_d.cnt = s_q.tmo;  // start from the programmed value
          end
          s_d.en = s_q.en | wd[MB_EN];  // write of zero cannot disable
          s_d.rstEn = s_q.rstEn | wd[MB_RSTEN];
          // set wins over clear: fault flags set below override these, a guard keeps a same-cycle warning
          if (wd[MB_TOFLAG]) s_d.toFlag = 1'b0;
          if (wd[MB_WARN] && !(s_q.en && tick && s_q.cnt == s_q.warn)) begin
            s_d.warnFlag = 1'b0;
          end
          if (wd[MB_INT]) s_d.intFlag = 1'b0;
        end
        // values under the minimum are clamped, not stored
        OFS_TIMEOUT: s_d.tmo = (wd[CW-1:0] < TMIN) ? TMIN : wd[CW-1:0];
        OFS_WARN: s_d.warn = wd[CW-1:0];
        OFS_WINDOW: s_d.win = wd[CW-1:0];
        default: begin
        end
      endcase
    end
    if (s_q.en && goodFeed && !outWin) begin
      s_d.cnt = s_q.tmo;
    end
    // any fault: reset or interrupt, then disable
    if (fault) begin
      if (s_q.rstEn) begin
        s_d.chipRst = 1'b1;
        s_d.toFlag = 1'b1;
      end else begin
        s_d.intFlag = 1'b1;
      end
      s_d.en = 1'b0;
      s_d.rstEn = 1'b0;
      s_d.feedArm = 1'b0;
      s_d.cnt = s_q.tmo;
    end
    // address phase capture; reads answer in the data phase
    s_d.dWr = 1'b0;
    if (ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1]) begin
      s_d.dWr = ahbReq.hwrite;
      s_d.dAddr = ahbReq.haddr;
      s_d.rdata = rdVal(ahbReq.haddr, s_q);
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.tmo <= TRST;
      s_q.win <= WINRST;
      s_q.warn <= WARNRST;
      s_q.cnt <= TRST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;  // zero wait states keeps the slave simple
  assign hresp = 1'b0;
  assign chipResetReq = s_q.chipRst;
  assign wdtIrq = s_q.warnFlag | s_q.intFlag;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_timeoutReset;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && s_q.rstEn && tick && s_q.cnt == '0) |=> (chipResetReq && !s_q.en);
  endproperty
  a_timeoutReset: assert property (p_timeoutReset) else $error("no reset on timeout");

  property p_window;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && goodFeed && s_q.cnt > s_q.win) |=> (!s_q.en && (chipResetReq || s_q.intFlag));
  endproperty
  a_window: assert property (p_window) else $error("early reload not faulted");

  property p_warn;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && tick && s_q.cnt == s_q.warn) |=> (s_q.warnFlag && wdtIrq);
  endproperty
  a_warn: assert property (p_warn) else $error("warning missed");

  property p_noDisable;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && !fault) |=> s_q.en;
  endproperty
  a_noDisable: assert property (p_noDisable) else $error("enable dropped");

  property p_badFeed;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && badFeed) |=> ((chipResetReq && s_q.toFlag) || s_q.intFlag);
  endproperty
  a_badFeed: assert property (p_badFeed) else $error("bad feed ignored");

  property p_flag;
    @(posedge clk) disable iff (!rst_b)
      $rose(chipResetReq) |-> s_q.toFlag;
  endproperty
  a_flag: assert property (p_flag) else $error("reset flag not set");

  property p_presc;
    @(posedge clk) disable iff (!rst_b)
      tick |=> !tick [*3];
  endproperty
  a_presc: assert property (p_presc) else $error("ticks too close");

  property p_minTmo;
    @(posedge clk) disable iff (!rst_b)
      s_q.dWr |=> (s_q.tmo >= TMIN);
  endproperty
  a_minTmo: assert property (p_minTmo) else $error("timeout below minimum");

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && goodFeed && !fault) |=> (s_q.cnt == $past(s_q.tmo));
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");

  property p_rstPulse;
    @(posedge clk) disable iff (!rst_b)
      chipResetReq |=> !chipResetReq;
  endproperty
  a_rstPulse: assert property (p_rstPulse) else $error("reset request too long");

  // ----------------------------------------
  // checks on counter, flags and faults
  // ----------------------------------------
  // enabling from idle starts the count from the programmed value
  property p_enLoad;
    @(posedge clk) disable iff (!rst_b)
      (s_q.dWr && s_q.dAddr == OFS_MODE && ahbReq.hwdata[MB_EN] && !s_q.en)
        |=> (s_q.en && s_q.cnt == $past(s_q.tmo));
  endproperty
  a_enLoad: assert property (p_enLoad) else $error("enable did not load timeout");

  // a plain tick takes exactly one off the count
  property p_countDown;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && tick && !fault && !goodFeed) |=> (s_q.cnt == $past(s_q.cnt) - 24'd1);
  endproperty
  a_countDown: assert property (p_countDown) else $error("count step wrong");

  // without a tick or a bus write the count must not move
  property p_countHold;
    @(posedge clk) disable iff (!rst_b)
      (!tick && !s_q.dWr && !fault) |=> $stable(s_q.cnt);
  endproperty
  a_countHold: assert property (p_countHold) else $error("count moved without tick");

  // a disabled watchdog never asks for a chip reset
  property p_offHold;
    @(posedge clk) disable iff (!rst_b)
      !s_q.en |=> !chipResetReq;
  endproperty
  a_offHold: assert property (p_offHold) else $error("reset while disabled");

  // interrupt-only mode raises the line instead of a reset
  property p_irqMode;
    @(posedge clk) disable iff (!rst_b)
      (fault && !s_q.rstEn) |=> (s_q.intFlag && wdtIrq && !chipResetReq);
  endproperty
  a_irqMode: assert property (p_irqMode) else $error("fault interrupt missing");

  // reset mode pulses the chip reset and marks its cause
  property p_rstMode;
    @(posedge clk) disable iff (!rst_b)
      (fault && s_q.rstEn) |=> (chipResetReq && s_q.toFlag);
  endproperty
  a_rstMode: assert property (p_rstMode) else $error("fault reset missing");

  // the cause flag survives until software clears it
  property p_toHold;
    @(posedge clk) disable iff (!rst_b)
      (s_q.toFlag && !(s_q.dWr && s_q.dAddr == OFS_MODE)) |=> s_q.toFlag;
  endproperty
  a_toHold: assert property (p_toHold) else $error("reset flag lost");

  // the warning stays pending until software clears it
  property p_warnHold;
    @(posedge clk) disable iff (!rst_b)
      (s_q.warnFlag && !(s_q.dWr && s_q.dAddr == OFS_MODE)) |=> s_q.warnFlag;
  endproperty
  a_warnHold: assert property (p_warnHold) else $error("warning flag lost");

  // the first feed byte arms the sequence
  property p_feedArm;
    @(posedge clk) disable iff (!rst_b)
      (feedWr && !s_q.feedArm && ahbReq.hwdata[7:0] == FEED1 && !fault) |=> s_q.feedArm;
  endproperty
  a_feedArm: assert property (p_feedArm) else $error("feed not armed");

  // any fault leaves the watchdog disabled and disarmed
  property p_faultOff;
    @(posedge clk) disable iff (!rst_b)
      fault |=> (!s_q.en && !s_q.rstEn && !s_q.feedArm);
  endproperty
  a_faultOff: assert property (p_faultOff) else $error("fault left watchdog on");

  // a feed inside the window keeps the watchdog running
  property p_inWindow;
    @(posedge clk) disable iff (!rst_b)
      (s_q.en && goodFeed && s_q.cnt <= s_q.win && !timeoutEv) |=> (s_q.en && !chipResetReq);
  endproperty
  a_inWindow: assert property (p_inWindow) else $error("valid reload faulted");
endmodule // wwd_windowed_watchdog
